/* File: verilog/cpbg_consts.svh */
// constants for the control-pin and bus-grant block
//
// Behaviour
// - processor cycle is half an input clock
// - reset held low at least five cycles
// - reset covers 2000 input clocks of lock
// - mode inputs stable around reset release
// - interrupt and flag inputs sampled per cycle
// - edge interrupt pulses longer than 10 ns
// - level interrupt held low until serviced
// - flag outputs change on output clock fall
// - bus request synchronised before use
// - strobes float before grant goes low
// - grant returns high before strobes drive
// - grant-hang only after strobes floated
`ifndef CPBG_CONSTS_SVH
`define CPBG_CONSTS_SVH
// ==========================================
// timing
`define CPBG_CLK_PERIOD_NS 4
`define CPBG_RESET_MIN_CYC 5
`define CPBG_LOCK_IN_CLKS 2000
`define CPBG_EDGE_PULSE_NS 10
`define CPBG_EDGE_PULSE_CYC ((`CPBG_EDGE_PULSE_NS + `CPBG_CLK_PERIOD_NS - 1) / `CPBG_CLK_PERIOD_NS)
// ==========================================
// widths and reset values
`define CPBG_NUM_SEL 5
`define CPBG_NUM_PF 8
`define CPBG_NUM_IRQ 6
`define CPBG_MODE_W 4
`define CPBG_SEL_IDLE 5'h1f
`endif

/* File: verilog/cpbg_pkg.sv */
// types for the control-pin and bus-grant block
`include "cpbg_consts.svh"
package cpbg_pkg;
  typedef logic [`CPBG_NUM_SEL-1:0] cpbg_sel_t;
  typedef logic [`CPBG_NUM_PF-1:0] cpbg_pf_t;
  typedef logic [`CPBG_NUM_IRQ-1:0] cpbg_irq_t;
  typedef logic [`CPBG_MODE_W-1:0] cpbg_mode_t;
  typedef enum logic [1:0] {
    CPBG_OWN = 2'b00,
    CPBG_FLOAT = 2'b01,
    CPBG_GRANTED = 2'b10,
    CPBG_RECLAIM = 2'b11
  } cpbg_bus_e;
endpackage : cpbg_pkg

/* File: verilog/cpbg_if.sv */
// pins between the processor end and the external bus master
`timescale 1ns/1ps
`default_nettype none
`include "cpbg_consts.svh"
interface cpbg_if;
  import cpbg_pkg::*;
  logic bus_request_n;
  logic bus_grant_n;
  logic grant_hang_n;
  cpbg_sel_t memory_space_selects;
  logic rd_n;
  logic wr_n;
  logic strobe_oe_n;
  cpbg_sel_t ext_selects;
  logic ext_rd_n;
  logic ext_wr_n;
  logic ext_oe_n;
  logic cycle_clock_output;
  // resolved bus levels, pulled high when nobody drives
  wire [`CPBG_NUM_SEL-1:0] sel_bus = !strobe_oe_n ? memory_space_selects :
                                     !ext_oe_n ? ext_selects : `CPBG_SEL_IDLE;
  wire rd_bus = !strobe_oe_n ? rd_n : !ext_oe_n ? ext_rd_n : 1'b1;
  wire wr_bus = !strobe_oe_n ? wr_n : !ext_oe_n ? ext_wr_n : 1'b1;
  modport device (input bus_request_n, output bus_grant_n, output grant_hang_n,
    output memory_space_selects, output rd_n, output wr_n, output strobe_oe_n,
    output cycle_clock_output);
  modport master (output bus_request_n, input bus_grant_n, input grant_hang_n,
    output ext_selects, output ext_rd_n, output ext_wr_n, output ext_oe_n,
    input cycle_clock_output);
endinterface : cpbg_if
`default_nettype wire

/* File: verilog/cpbg_device.sv */
// processor end: cycle clock, reset and mode latch, input sampling, flags, bus grant
`timescale 1ns/1ps
`default_nettype none
`include "cpbg_consts.svh"
module cpbg_device #(
  parameter int LOCK_CYCLES = 2 * `CPBG_LOCK_IN_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cpbg_if.device bus,
  input wire cpbg_pkg::cpbg_mode_t mode_pins,
  input wire cpbg_pkg::cpbg_irq_t irq_pins_n,
  input wire logic flag_in_pin,
  input wire cpbg_pkg::cpbg_pf_t pf_in,
  input wire cpbg_pkg::cpbg_sel_t core_selects_n,
  input wire logic core_rd_n,
  input wire logic core_wr_n,
  input wire logic core_needs_bus,
  input wire cpbg_pkg::cpbg_pf_t pf_out_set,
  input wire logic [2:0] out_flags_set,
  input wire logic flag_out_set,
  input wire cpbg_pkg::cpbg_irq_t irq_clear,
  output logic ready,
  output cpbg_pkg::cpbg_mode_t mode_latched,
  output cpbg_pkg::cpbg_irq_t irq_pending,
  output logic flag_in_seen,
  output cpbg_pkg::cpbg_pf_t pf_seen,
  output cpbg_pkg::cpbg_pf_t programmable_flags,
  output logic output_flag_0,
  output logic output_flag_1,
  output logic output_flag_2,
  output logic flag_out_pin,
  output logic core_stall
);
  import cpbg_pkg::*;
  // ==========================================
  // elaboration checks
  // the lock counter is sixteen bits wide
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_bad_lock
    $error("LOCK_CYCLES out of range");
  end
  // the level mask assumes six interrupt lines
  if (`CPBG_NUM_IRQ != 6) begin : g_bad_irq
    $error("interrupt count must be six");
  end
  // ==========================================
  // state
  typedef struct packed {
    logic phase;
    logic [15:0] lock_cnt;
    logic ready;
    logic mode_taken;
    cpbg_mode_t mode;
    logic req_s1;
    logic req_s2;
    cpbg_irq_t irq_s;
    cpbg_irq_t irq_prev;
    cpbg_irq_t pend;
    logic fi;
    cpbg_pf_t pfi;
    cpbg_pf_t pfo;
    logic [2:0] fl;
    logic fo;
    cpbg_bus_e bst;
    cpbg_sel_t sel;
    logic rd;
    logic wr;
    logic oe_n;
    logic bg_n;
    logic bgh_n;
    logic stall;
  } cpbg_dev_s;
  cpbg_dev_s q, d;
  // ==========================================
  // reset state
  // strobes driven and idle, grant and hang released
  localparam cpbg_dev_s RST_STATE = '{
    phase: 1'b0,
    lock_cnt: 16'h0000,
    ready: 1'b0,
    mode_taken: 1'b0,
    mode: 4'h0,
    req_s1: 1'b0,
    req_s2: 1'b0,
    irq_s: 6'h00,
    irq_prev: 6'h00,
    pend: 6'h00,
    fi: 1'b0,
    pfi: 8'h00,
    pfo: 8'h00,
    fl: 3'h0,
    fo: 1'b0,
    bst: CPBG_OWN,
    sel: `CPBG_SEL_IDLE,
    rd: 1'b1,
    wr: 1'b1,
    oe_n: 1'b0,
    bg_n: 1'b1,
    bgh_n: 1'b1,
    stall: 1'b0
  };
  // irq 0..2 and edge irq are edge triggered, the two level irqs sit at 3 and 4
  localparam cpbg_irq_t LEVEL_MASK = 6'h18;
  // ==========================================
  // next state
  always_comb begin
    d = q;
    // ==========================================
    // cycle clock, lock and mode
    d.phase = ~q.phase;
    if (!q.ready) begin
      // the block stays parked until the multiplier would have locked
      if (q.lock_cnt == 16'(LOCK_CYCLES - 1)) d.ready = 1'b1;
      else d.lock_cnt = q.lock_cnt + 16'h1;
    end
    if (!q.mode_taken) begin
      d.mode_taken = 1'b1;
      d.mode = mode_pins;
    end
    // ==========================================
    // input sampling
    // sample on every cycle edge; a late arrival is seen one cycle on
    d.irq_s = ~irq_pins_n;
    d.irq_prev = q.irq_s;
    d.fi = flag_in_pin;
    d.pfi = pf_in;
    // set wins over clear; edge pulses over one cycle are caught
    d.pend = (q.pend & ~irq_clear) | (q.irq_s & ~q.irq_prev & ~LEVEL_MASK)
             | (q.irq_s & LEVEL_MASK);
    // ==========================================
    // flag outputs
    if (q.phase) begin
      // output clock is falling here
      d.pfo = pf_out_set;
      d.fl = out_flags_set;
      d.fo = flag_out_set;
    end
    // ==========================================
    // bus hand-over
    d.req_s1 = ~bus.bus_request_n;
    d.req_s2 = q.req_s1;
    d.sel = core_selects_n;
    d.rd = core_rd_n;
    d.wr = core_wr_n;
    d.stall = 1'b0;
    unique case (q.bst)
      CPBG_OWN: begin
        // acting while the cycle clock is high makes the float land on its fall
        if (q.req_s2 && q.ready && q.phase) begin
          d.oe_n = 1'b1;
          d.bst = CPBG_FLOAT;
        end
      end
      CPBG_FLOAT: begin
        d.bg_n = 1'b0;
        d.bst = CPBG_GRANTED;
      end
      CPBG_GRANTED: begin
        d.bgh_n = ~core_needs_bus;
        d.stall = core_needs_bus;
        if (!q.req_s2) begin
          d.bg_n = 1'b1;
          d.bgh_n = 1'b1;
          d.bst = CPBG_RECLAIM;
        end
      end
      CPBG_RECLAIM: begin
        d.stall = core_needs_bus;
        // strobes return while the cycle clock is low, on the edge of its rise
        if (!q.phase) begin
          d.oe_n = 1'b0;
          d.bst = CPBG_OWN;
        end
      end
    endcase
  end
  // ==========================================
  // registers; reset low must last the minimum width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else if (clk_en) begin
      // clk_en low freezes every flop, the cycle clock too
      q <= d;
    end
  end
  // ==========================================
  // outputs, all from flip-flops
  assign bus.cycle_clock_output = q.phase;
  assign bus.bus_grant_n = q.bg_n;
  assign bus.grant_hang_n = q.bgh_n;
  assign bus.memory_space_selects = q.sel;
  assign bus.rd_n = q.rd;
  assign bus.wr_n = q.wr;
  assign bus.strobe_oe_n = q.oe_n;
  assign ready = q.ready;
  assign mode_latched = q.mode;
  assign irq_pending = q.pend;
  assign flag_in_seen = q.fi;
  assign pf_seen = q.pfi;
  assign programmable_flags = q.pfo;
  assign output_flag_0 = q.fl[0];
  assign output_flag_1 = q.fl[1];
  assign output_flag_2 = q.fl[2];
  assign flag_out_pin = q.fo;
  assign core_stall = q.stall;
endmodule : cpbg_device
`default_nettype wire

/* File: verilog/cpbg_master.sv */
// external bus master end: requests the bus and drives it only while granted
`timescale 1ns/1ps
`default_nettype none
`include "cpbg_consts.svh"
module cpbg_master (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cpbg_if.master bus,
  input wire logic want_bus,
  input wire cpbg_pkg::cpbg_sel_t user_selects_n,
  input wire logic user_rd_n,
  input wire logic user_wr_n,
  output logic have_bus,
  output logic hang_seen
);
  import cpbg_pkg::*;
  // ==========================================
  // state
  typedef struct packed {
    logic req;
    logic gnt_s;
    logic drive;
    logic hang;
    cpbg_sel_t sel;
    logic rd;
    logic wr;
  } cpbg_mst_s;
  cpbg_mst_s q, d;
  always_comb begin
    d = q;
    d.gnt_s = ~bus.bus_grant_n;
    // the request stays up while the bus is used
    d.req = want_bus | q.drive;
    d.drive = want_bus & q.gnt_s & ~bus.bus_grant_n;
    d.hang = ~bus.grant_hang_n;
    d.sel = d.drive ? user_selects_n : `CPBG_SEL_IDLE;
    d.rd = ~d.drive | user_rd_n;
    d.wr = ~d.drive | user_wr_n;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.sel <= `CPBG_SEL_IDLE;
      q.rd <= 1'b1;
      q.wr <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end
  // ==========================================
  // outputs; enable low means driving
  assign bus.bus_request_n = ~q.req;
  assign bus.ext_oe_n = ~q.drive;
  assign bus.ext_selects = q.sel;
  assign bus.ext_rd_n = q.rd;
  assign bus.ext_wr_n = q.wr;
  assign have_bus = q.drive;
  assign hang_seen = q.hang;
endmodule : cpbg_master
`default_nettype wire

/* File: verification/cpbg_chk.sv */
// hand-over checks on the pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module cpbg_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic grant_hang_n,
  input wire logic strobe_oe_n,
  input wire logic ext_oe_n,
  input wire logic cycle_clock_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  // clk_en stays high in the bench, so the cycle clock must move every edge
  a_cyc_toggle: assert property (1'b1 |=> $changed(cycle_clock_output)) else $error("cycle clock stuck");
  a_float_phase: assert property ($rose(strobe_oe_n) |-> $past(cycle_clock_output) && bus_grant_n)
    else $error("float off phase");
  a_grant_sync: assert property ($fell(bus_grant_n) |-> $past(strobe_oe_n) && !$past(bus_request_n, 3))
    else $error("grant too early");
  a_reclaim_order: assert property ($fell(strobe_oe_n) |-> bus_grant_n && grant_hang_n && !$past(cycle_clock_output))
    else $error("drive before release");
  a_hang_float: assert property (!grant_hang_n |-> strobe_oe_n && !bus_grant_n) else $error("hang while driving");
  a_grant_hold: assert property ((!bus_grant_n && !bus_request_n) [*3] |=> !bus_grant_n)
    else $error("grant dropped");
  a_release_bound: assert property ($rose(bus_request_n) |-> ##[1:4] bus_grant_n) else $error("grant kept");
  a_master_drive: assert property (!ext_oe_n |-> !bus_grant_n && strobe_oe_n) else $error("master drives early");
endmodule : cpbg_chk
`default_nettype wire

/* File: verification/cpbg_tb_top.sv */
// bench joining the processor end and the bus master end
`timescale 1ns/1ps
`default_nettype none
module cpbg_tb_top;
  import cpbg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  cpbg_mode_t mode_pins = 4'ha;
  cpbg_mode_t mode_latched;
  cpbg_irq_t irq_pins_n = 6'h3f;
  cpbg_irq_t irq_clear = 6'h00;
  cpbg_irq_t irq_pending;
  cpbg_pf_t pf_in = 8'h00;
  cpbg_pf_t pf_out_set = 8'h00;
  cpbg_pf_t pf_seen;
  cpbg_pf_t programmable_flags;
  cpbg_sel_t core_selects_n = 5'h1e;
  cpbg_sel_t user_selects_n = 5'h15;
  logic [2:0] out_flags_set = 3'h0;
  logic flag_in_pin = 1'b0;
  logic flag_out_set = 1'b0;
  logic core_rd_n = 1'b0;
  logic core_wr_n = 1'b1;
  logic user_rd_n = 1'b1;
  logic user_wr_n = 1'b0;
  logic core_needs_bus = 1'b0;
  logic want_bus = 1'b0;
  logic ready, flag_in_seen, output_flag_0, output_flag_1, output_flag_2;
  logic flag_out_pin, core_stall, have_bus, hang_seen;
  int n_errors = 0;
  int cmp_count = 0;
  cpbg_if cif ();
  // short lock count keeps the run brief
  cpbg_device #(.LOCK_CYCLES(8)) cpbg_device_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus(cif),
    .mode_pins(mode_pins), .irq_pins_n(irq_pins_n), .flag_in_pin(flag_in_pin), .pf_in(pf_in),
    .core_selects_n(core_selects_n), .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
    .core_needs_bus(core_needs_bus), .pf_out_set(pf_out_set), .out_flags_set(out_flags_set),
    .flag_out_set(flag_out_set), .irq_clear(irq_clear), .ready(ready), .mode_latched(mode_latched),
    .irq_pending(irq_pending), .flag_in_seen(flag_in_seen), .pf_seen(pf_seen),
    .programmable_flags(programmable_flags), .output_flag_0(output_flag_0), .output_flag_1(output_flag_1),
    .output_flag_2(output_flag_2), .flag_out_pin(flag_out_pin), .core_stall(core_stall));
  cpbg_master cpbg_master_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus(cif), .want_bus(want_bus),
    .user_selects_n(user_selects_n), .user_rd_n(user_rd_n), .user_wr_n(user_wr_n), .have_bus(have_bus),
    .hang_seen(hang_seen));
  cpbg_chk cpbg_chk_inst (.clk(clk), .rst_n(rst_n), .bus_request_n(cif.bus_request_n),
    .bus_grant_n(cif.bus_grant_n), .grant_hang_n(cif.grant_hang_n), .strobe_oe_n(cif.strobe_oe_n),
    .ext_oe_n(cif.ext_oe_n), .cycle_clock_output(cif.cycle_clock_output));
  always #2 clk = ~clk;
  // ==========
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : edges
  task automatic clr;
    @(posedge clk) irq_clear <= 6'h3f;
    @(posedge clk) irq_clear <= 6'h00;
    edges(2);
  endtask : clr
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    test_done();
  end
  // ==========
  // tests
  initial begin
    repeat (8) @(posedge clk);
    // request raised at release is held off until lock is done
    @(posedge clk) begin
      rst_n <= 1'b1;
      want_bus <= 1'b1;
    end
    edges(7);
    chk(ready, 8'h0);
    chk(cif.bus_grant_n, 8'h1);
    @(posedge clk) mode_pins <= 4'h5;
    edges(2);
    chk(ready, 8'h1);
    chk(mode_latched, 8'ha);
    for (int i = 0; i < 40 && have_bus !== 1'b1; i++) edges(1);
    chk(cif.bus_grant_n, 8'h0);
    chk(cif.sel_bus, 8'h15);
    chk(cif.rd_bus, 8'h1);
    chk(cif.wr_bus, 8'h0);
    @(posedge clk) core_needs_bus <= 1'b1;
    edges(3);
    chk({core_stall, hang_seen, cif.grant_hang_n}, 8'h6);
    @(posedge clk) want_bus <= 1'b0;
    for (int i = 0; i < 40 && cif.strobe_oe_n !== 1'b0; i++) edges(1);
    chk({cif.bus_grant_n, cif.grant_hang_n}, 8'h3);
    chk(cif.sel_bus, 8'h1e);
    chk(cif.rd_bus, 8'h0);
    chk(cif.wr_bus, 8'h1);
    @(posedge clk) core_needs_bus <= 1'b0;
    $display("bus test done");
    @(posedge clk) begin
      irq_pins_n <= 6'h00;
      flag_in_pin <= 1'b1;
      pf_in <= 8'h5a;
    end
    // three cycles is 12 ns, beyond the edge pulse minimum
    repeat (3) @(posedge clk);
    irq_pins_n <= 6'h3f;
    edges(3);
    chk(irq_pending, 8'h3f);
    chk({flag_in_seen, pf_seen[6:0]}, 8'hda);
    clr();
    chk(irq_pending, 8'h00);
    @(posedge clk) irq_pins_n <= 6'h00;
    edges(4);
    clr();
    chk(irq_pending, 8'h18);
    @(posedge clk) irq_pins_n <= 6'h3f;
    clr();
    chk(irq_pending, 8'h00);
    $display("irq test done");
    do edges(1); while (cif.cycle_clock_output !== 1'b1);
    @(posedge clk) begin
      pf_out_set <= 8'ha5;
      out_flags_set <= 3'h5;
      flag_out_set <= 1'b1;
    end
    edges(1);
    chk({flag_out_pin, output_flag_2, output_flag_1, output_flag_0}, 8'h0);
    edges(1);
    chk({flag_out_pin, output_flag_2, output_flag_1, output_flag_0}, 8'hd);
    chk(programmable_flags, 8'ha5);
    $display("flag test done");
    test_done();
  end
endmodule : cpbg_tb_top
`default_nettype wire
